// file: hw/mrs_regs.vh
/*
  register offsets, mode encodings, reset values and timing counts of the
  motor restart sequencer. assumes an apb slave with 32-bit data and
  byte addresses, clock at 20 mhz.

*/
`ifndef MRS_REGS_VH
`define MRS_REGS_VH

`define MRS_ADDR_FLY_CFG      12'h000
`define MRS_ADDR_SEARCH       12'h004
`define MRS_ADDR_AR_CFG       12'h008
`define MRS_ADDR_WAIT         12'h00c
`define MRS_ADDR_CTRL         12'h010
`define MRS_ADDR_STATUS       12'h014
`define MRS_ADDR_SEARCH_OUT   12'h018

`define MRS_FLY_MODE_OFF      8'h00
`define MRS_FLY_MODE_BOTH     8'h01
`define MRS_FLY_MODE_SETP     8'h04

`define MRS_AR_OFF            8'h00
`define MRS_AR_ACK_ONLY       8'h01
`define MRS_AR_PF             8'h04
`define MRS_AR_FAULT          8'h06
`define MRS_AR_PF_MAN         8'h0e
`define MRS_AR_FAULT_MAN      8'h10
`define MRS_AR_ALL_RUN        8'h1a

`define MRS_RST_FLY_MODE      8'h00
`define MRS_RST_FLY_EN        1'b1
`define MRS_RST_PCT           8'h64
`define MRS_RST_AR_MODE       8'h00
`define MRS_RST_LIMIT         8'h03
`define MRS_RST_WAIT_MS       16'h03e8

`define MRS_CLK_HZ            20000000
`define MRS_MS_CYCLES         (`MRS_CLK_HZ / 1000)
`define MRS_SUCCESS_MS        16'h03e8
`define MRS_SWEEP_BASE_CYC    16'h0014

`endif

// file: hw/mrs_tick.v
/*
  divider that turns the system clock into a one-cycle millisecond enable,
  and a base sweep-step enable stretched by the search speed factor.
  assumes pclk at the rate in the header.
*/
`timescale 1ns/100ps
`include "mrs_regs.vh"
module mrs_tick #(
  parameter MS_CYCLES = `MRS_MS_CYCLES
) (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [7:0] speed_factor,
  output reg        ms_tick,
  output reg        sweep_tick
);
  reg [31:0] ms_cnt;
  reg [23:0] sw_cnt;
  wire [23:0] sw_len;

  // larger factor means a longer step, so a slower sweep
  assign sw_len = {16'h0000, speed_factor} * {8'h00, `MRS_SWEEP_BASE_CYC} / 24'd100 + 24'd1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt     <= 32'h0;
      sw_cnt     <= 24'h0;
      ms_tick    <= 1'b0;
      sweep_tick <= 1'b0;
    end else begin
      ms_tick    <= (ms_cnt == MS_CYCLES - 1);
      ms_cnt     <= (ms_cnt == MS_CYCLES - 1) ? 32'h0 : ms_cnt + 32'h1;
      sweep_tick <= (sw_cnt >= sw_len - 24'd1);
      sw_cnt     <= (sw_cnt >= sw_len - 24'd1) ? 24'h0 : sw_cnt + 24'h1;
    end
  end
endmodule

// file: hw/mrs_sequencer.v
/*
  motor restart sequencer: flying restart speed search and automatic
  restart decisions, configured over apb. assumes fault, run and speed
  inputs synchronous to pclk, and a power stage that reports magnetizing.
*/
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "mrs_regs.vh"
module mrs_sequencer #(
  parameter FREQ_W    = 16,
  parameter MS_CYCLES = `MRS_MS_CYCLES
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              run_command,
  input  wire              fly_enable_source,
  input  wire              setpoint_neg,
  input  wire [FREQ_W-1:0] motor_speed,
  input  wire              speed_found,
  input  wire [15:0]       magnetizing_current_ref,
  input  wire              magnetizing_done_flag,
  input  wire              fault_undervolt,
  input  wire              fault_supply_loss,
  input  wire              fault_other,
  output reg               stage_on,
  output reg               ramp_enable,
  output reg               search_active,
  output reg               search_neg,
  output reg  [FREQ_W-1:0] output_freq,
  output reg  [15:0]       search_current,
  output reg               fault_ack,
  output reg               restart_failed,
  output reg               start_success
);
  localparam ST_IDLE   = 3'd0;
  localparam ST_SEARCH = 3'd1;
  localparam ST_MAGN   = 3'd2;
  localparam ST_CHECK  = 3'd3;
  localparam ST_RUN    = 3'd4;
  localparam ST_FAULT  = 3'd5;
  localparam ST_WAIT   = 3'd6;
  localparam ST_FAILED = 3'd7;

  reg [7:0]  fly_mode_sel;
  reg        fly_en_use_src;
  reg [7:0]  search_current_pct;
  reg [7:0]  search_speed_factor;
  reg [7:0]  autorestart_mode_sel;
  reg [7:0]  start_attempt_limit;
  reg [15:0] attempt_wait_interval;
  reg        manual_ack;
  reg [2:0]  state;
  reg [2:0]  next_state;
  reg [8:0]  attempts;
  reg [15:0] ms_cnt;
  reg        power_fail;
  reg        sweep_dir_done;
  reg        cfg_changed;
  wire       ms_tick;
  wire       sweep_tick;
  wire       any_fault;
  wire       fly_allowed;
  wire       apb_wr;
  wire       apb_rd;
  wire [31:0] cur_prod;
  wire [31:0] cur_scaled;

  function ack_allowed;
    input [7:0] mode;
    input       run;
    begin
      case (mode)
        `MRS_AR_ACK_ONLY, `MRS_AR_ALL_RUN: ack_allowed = 1'b1;
        `MRS_AR_PF, `MRS_AR_FAULT:         ack_allowed = run;
        default:                           ack_allowed = 1'b0;
      endcase
    end
  endfunction

  function restart_allowed;
    input [7:0] mode;
    input       run;
    begin
      case (mode)
        `MRS_AR_PF, `MRS_AR_FAULT, `MRS_AR_PF_MAN, `MRS_AR_FAULT_MAN,
        `MRS_AR_ALL_RUN: restart_allowed = run;
        default:         restart_allowed = 1'b0;
      endcase
    end
  endfunction

  function waits_between;
    input [7:0] mode;
    begin
      waits_between = (mode == `MRS_AR_PF) || (mode == `MRS_AR_FAULT) ||
                      (mode == `MRS_AR_ALL_RUN);
    end
  endfunction

  mrs_tick #(
    .MS_CYCLES(MS_CYCLES)
  ) u_tick (
    .pclk        (pclk),
    .presetn     (presetn),
    .speed_factor(search_speed_factor),
    .ms_tick     (ms_tick),
    .sweep_tick  (sweep_tick)
  );

  assign any_fault   = fault_undervolt | fault_supply_loss | fault_other;
  // software may tie enable high, or follow the external source
  assign fly_allowed = fly_en_use_src ? fly_enable_source : 1'b1;
  assign apb_wr      = psel & penable & pwrite;
  assign apb_rd      = psel & ~penable & ~pwrite;
  assign cur_prod    = {16'h0000, magnetizing_current_ref} * {24'h0, search_current_pct};
  // divide before cutting: the product needs up to 24 bits
  assign cur_scaled  = cur_prod / 32'd100;

  // register writes; zero-wait slave
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fly_mode_sel          <= `MRS_RST_FLY_MODE;
      fly_en_use_src        <= 1'b0;
      search_current_pct    <= `MRS_RST_PCT;
      search_speed_factor   <= `MRS_RST_PCT;
      autorestart_mode_sel  <= `MRS_RST_AR_MODE;
      start_attempt_limit   <= `MRS_RST_LIMIT;
      attempt_wait_interval <= `MRS_RST_WAIT_MS;
      manual_ack            <= 1'b0;
      cfg_changed           <= 1'b0;
    end else begin
      manual_ack  <= 1'b0;
      cfg_changed <= 1'b0;
      if (apb_wr) begin
        case (paddr)
          `MRS_ADDR_FLY_CFG: begin
            fly_mode_sel   <= pwdata[7:0];
            fly_en_use_src <= pwdata[8];
          end
          `MRS_ADDR_SEARCH: begin
            search_current_pct  <= pwdata[7:0];
            search_speed_factor <= pwdata[15:8];
          end
          `MRS_ADDR_AR_CFG: begin
            autorestart_mode_sel <= pwdata[7:0];
            start_attempt_limit  <= pwdata[15:8];
            cfg_changed          <= 1'b1;
          end
          `MRS_ADDR_WAIT: attempt_wait_interval <= pwdata[15:0];
          `MRS_ADDR_CTRL: manual_ack <= pwdata[0];
          default: ;
        endcase
      end
    end
  end

  // read data, answer and unmapped error
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        pslverr <= (paddr > `MRS_ADDR_SEARCH_OUT) || (paddr[1:0] != 2'b00);
      end
      if (apb_rd) begin
        case (paddr)
          `MRS_ADDR_FLY_CFG:    prdata <= {23'h0, fly_en_use_src, fly_mode_sel};
          `MRS_ADDR_SEARCH:     prdata <= {16'h0, search_speed_factor, search_current_pct};
          `MRS_ADDR_AR_CFG:     prdata <= {16'h0, start_attempt_limit, autorestart_mode_sel};
          `MRS_ADDR_WAIT:       prdata <= {16'h0, attempt_wait_interval};
          `MRS_ADDR_STATUS:     prdata <= {19'h0, attempts, power_fail, state};
          `MRS_ADDR_SEARCH_OUT: prdata <= {{(32-FREQ_W){1'b0}}, output_freq};
          default:              prdata <= 32'h0;
        endcase
      end
    end
  end

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (any_fault)
          next_state = ST_FAULT;
        else if (run_command)
          // without search a spinning motor trips on overcurrent
          next_state = (fly_mode_sel != `MRS_FLY_MODE_OFF && fly_allowed) ?
                       ST_SEARCH : ST_MAGN;
      end
      ST_SEARCH: begin
        if (any_fault)
          next_state = ST_FAULT;
        else if (!run_command)
          next_state = ST_IDLE;
        else if (speed_found)
          next_state = ST_MAGN;
      end
      ST_MAGN: begin
        if (any_fault)
          next_state = ST_FAULT;
        else if (!run_command)
          next_state = ST_IDLE;
        else if (magnetizing_done_flag)
          next_state = ST_CHECK;
      end
      ST_CHECK: begin
        if (any_fault)
          next_state = ST_FAULT;
        else if (!run_command)
          next_state = ST_IDLE;
        // tick phase is free running, one extra tick guarantees a full second
        else if (ms_tick && ms_cnt == `MRS_SUCCESS_MS)
          next_state = ST_RUN;
      end
      ST_RUN: begin
        if (any_fault)
          next_state = ST_FAULT;
        else if (!run_command)
          next_state = ST_IDLE;
      end
      ST_FAULT: begin
        if (attempts > {1'b0, start_attempt_limit})
          next_state = ST_FAILED;
        else if (!any_fault &&
                 (manual_ack || ack_allowed(autorestart_mode_sel, run_command))) begin
          if (restart_allowed(autorestart_mode_sel, run_command) &&
              (autorestart_mode_sel != `MRS_AR_PF || power_fail))
            next_state = waits_between(autorestart_mode_sel) ? ST_WAIT : ST_IDLE;
          else if (!run_command)
            next_state = ST_IDLE;
        end
      end
      ST_WAIT: begin
        if (ms_tick && ms_cnt >= attempt_wait_interval)
          next_state = ST_IDLE;
      end
      ST_FAILED: begin
        if (!run_command && manual_ack)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state          <= ST_IDLE;
      attempts       <= 9'h0;
      ms_cnt         <= 16'h0;
      power_fail     <= 1'b0;
      sweep_dir_done <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state != state)
        ms_cnt <= 16'h0;
      else if (ms_tick)
        ms_cnt <= ms_cnt + 16'h1;
      if (state != ST_FAULT && next_state == ST_FAULT) begin
        attempts   <= attempts + 9'h1;
        power_fail <= fault_undervolt | fault_supply_loss;
      end
      if (cfg_changed || (state == ST_RUN) ||
          (state == ST_FAILED && next_state == ST_IDLE))
        attempts <= 9'h0;
      if (state == ST_SEARCH && sweep_tick && output_freq == {FREQ_W{1'b0}})
        sweep_dir_done <= 1'b1;
      else if (state != ST_SEARCH)
        sweep_dir_done <= 1'b0;
    end
  end

  // outputs and frequency sweep
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_on       <= 1'b0;
      ramp_enable    <= 1'b0;
      search_active  <= 1'b0;
      search_neg     <= 1'b0;
      output_freq    <= {FREQ_W{1'b0}};
      search_current <= 16'h0;
      fault_ack      <= 1'b0;
      restart_failed <= 1'b0;
      start_success  <= 1'b0;
    end else begin
      stage_on       <= (next_state == ST_SEARCH) || (next_state == ST_MAGN) ||
                        (next_state == ST_CHECK) || (next_state == ST_RUN);
      ramp_enable    <= (next_state == ST_CHECK) || (next_state == ST_RUN);
      search_active  <= (next_state == ST_SEARCH);
      fault_ack      <= (state == ST_FAULT) && (next_state != ST_FAULT) &&
                        (next_state != ST_FAILED);
      restart_failed <= (next_state == ST_FAILED);
      start_success  <= (state == ST_CHECK) && (next_state == ST_RUN);
      search_current <= (next_state == ST_SEARCH) ? cur_scaled[15:0] : 16'h0;
      if (state != ST_SEARCH && next_state == ST_SEARCH) begin
        output_freq <= {FREQ_W{1'b1}};
        search_neg  <= (fly_mode_sel == `MRS_FLY_MODE_SETP) ? setpoint_neg : ~setpoint_neg;
      end else if (state == ST_SEARCH) begin
        if (speed_found) begin
          output_freq <= motor_speed;
          search_neg  <= search_neg;
        end else if (sweep_tick) begin
          if (output_freq != {FREQ_W{1'b0}})
            output_freq <= output_freq - {{(FREQ_W-1){1'b0}}, 1'b1};
          else if (fly_mode_sel == `MRS_FLY_MODE_BOTH && !sweep_dir_done) begin
            output_freq <= {FREQ_W{1'b1}};
            search_neg  <= ~search_neg;
          end else
            output_freq <= {FREQ_W{1'b1}};
        end
      end else if (next_state == ST_MAGN && state == ST_IDLE) begin
        output_freq <= {FREQ_W{1'b0}};
        search_neg  <= setpoint_neg;
      end else if (next_state == ST_CHECK) begin
        search_neg  <= setpoint_neg;
      end else if (next_state == ST_IDLE) begin
        output_freq <= {FREQ_W{1'b0}};
      end
    end
  end
endmodule

// file: bench/mrs_seq_monitor.sv
/*
  port checker of the restart sequencer: apb answer and sequencing order.
  assumes it is bound into mrs_sequencer and sees only its ports.
*/
`timescale 1ns/100ps
module mrs_seq_monitor (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire        run_command,
  input wire        setpoint_neg,
  input wire        magnetizing_done_flag,
  input wire        stage_on,
  input wire        ramp_enable,
  input wire        search_active,
  input wire        search_neg,
  input wire [15:0] search_current,
  input wire        fault_ack,
  input wire        restart_failed,
  input wire        start_success
);
  reg  [7:0] fly_mode;
  wire       wr_done = psel && penable && pready && pwrite;

  // shadow of the fly mode, so rules on it need no internal probe
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      fly_mode <= 8'h00;
    else if (wr_done && paddr == 12'h000)
      fly_mode <= pwdata[7:0];
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_pready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_err_unmapped: assert property (pready && paddr > 12'h018 |-> pslverr)
    else $error("no error on unmapped address");
  a_fly_off: assert property (fly_mode == 8'h00 |-> !search_active)
    else $error("search while flying restart locked");
  a_search_dir: assert property (fly_mode == 8'h04 && search_active |-> search_neg == setpoint_neg)
    else $error("search against setpoint direction");
  a_ramp_after_sync: assert property ($rose(ramp_enable) |-> !search_active && $past(stage_on))
    else $error("ramp before speed synchronisation");
  a_current_idle: assert property (!search_active && !$past(search_active) |-> search_current == 16'h0000)
    else $error("search current outside search");
  a_on_needs_run: assert property ($rose(stage_on) |-> $past(run_command))
    else $error("switch-on without run command");
  a_success_pulse: assert property (start_success |-> magnetizing_done_flag ##1 !start_success)
    else $error("success without magnetizing or too long");

  c_success: cover property (start_success);
  c_ack: cover property (fault_ack);
  c_failed: cover property (restart_failed);
endmodule

bind mrs_sequencer mrs_seq_monitor u_mon (
  .pclk                  (pclk),
  .presetn               (presetn),
  .psel                  (psel),
  .penable               (penable),
  .pwrite                (pwrite),
  .paddr                 (paddr),
  .pwdata                (pwdata),
  .pready                (pready),
  .pslverr               (pslverr),
  .run_command           (run_command),
  .setpoint_neg          (setpoint_neg),
  .magnetizing_done_flag (magnetizing_done_flag),
  .stage_on              (stage_on),
  .ramp_enable           (ramp_enable),
  .search_active         (search_active),
  .search_neg            (search_neg),
  .search_current        (search_current),
  .fault_ack             (fault_ack),
  .restart_failed        (restart_failed),
  .start_success         (start_success)
);

// file: bench/mrs_motor_model.sv
/*
  motor and power stage stand-in: search hit, magnetizing done, and an
  overcurrent when a spinning motor is started cold. assumes pclk domain.
*/
`timescale 1ns/100ps
module mrs_motor_model (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        stage_on,
  input  wire        search_active,
  input  wire        search_neg,
  input  wire [15:0] output_freq,
  input  wire [15:0] motor_speed,
  input  wire        motor_neg,
  input  wire        spinning,
  output reg         speed_found,
  output reg         magnetizing_done_flag,
  output reg         fault_other
);
  reg [3:0] mag_cnt;
  reg       synced;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_found <= 1'b0;
      magnetizing_done_flag <= 1'b0;
      fault_other <= 1'b0;
      mag_cnt <= 4'h0;
      synced <= 1'b0;
    end else begin
      // hit only when sweeping in the direction the shaft really turns
      speed_found <= search_active && search_neg == motor_neg && output_freq <= motor_speed;
      synced <= stage_on && (synced || speed_found);
      fault_other <= stage_on && spinning && !synced && !search_active;
      if (!stage_on || search_active)
        mag_cnt <= 4'h0;
      else if (mag_cnt != 4'hf)
        mag_cnt <= mag_cnt + 4'h1;
      magnetizing_done_flag <= mag_cnt >= 4'h8;
    end
  end
endmodule

// file: bench/mrs_sequencer_tb_top.sv
/*
  bench of the restart sequencer: apb master, motor stand-in and a
  reference of restart decisions. assumes the hand-over timing figures.
*/
`timescale 1ns/100ps
module mrs_sequencer_tb_top;
  localparam MS = 20;
  reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h00000000, rd, seed = 32'h0000004f;
  reg         err, run_command = 0, fly_enable_source = 0, setpoint_neg = 0;
  reg         fault_undervolt = 0, fault_supply_loss = 0, spinning = 0, motor_neg = 0;
  reg  [15:0] motor_speed = 16'hfff0, magnetizing_current_ref = 16'h0000;
  wire [31:0] prdata;
  wire [15:0] output_freq, search_current;
  wire        pready, pslverr, stage_on, ramp_enable, search_active, search_neg;
  wire        fault_ack, restart_failed, start_success, speed_found;
  wire        magnetizing_done_flag, fault_other;
  wire [7:0]  mon = {start_success, fault_ack, restart_failed, ramp_enable,
                     search_active, stage_on, magnetizing_done_flag, fault_other};
  integer     mismatches = 0, total_checks = 0, k, m, wt, t1, t2;
  integer     modes[$] = '{1, 4, 6, 14, 16, 26};

  mrs_sequencer #(.FREQ_W(16), .MS_CYCLES(MS)) uut (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .psel                    (psel),
    .penable                 (penable),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdata                  (pwdata),
    .prdata                  (prdata),
    .pready                  (pready),
    .pslverr                 (pslverr),
    .run_command             (run_command),
    .fly_enable_source       (fly_enable_source),
    .setpoint_neg            (setpoint_neg),
    .motor_speed             (motor_speed),
    .speed_found             (speed_found),
    .magnetizing_current_ref (magnetizing_current_ref),
    .magnetizing_done_flag   (magnetizing_done_flag),
    .fault_undervolt         (fault_undervolt),
    .fault_supply_loss       (fault_supply_loss),
    .fault_other             (fault_other),
    .stage_on                (stage_on),
    .ramp_enable             (ramp_enable),
    .search_active           (search_active),
    .search_neg              (search_neg),
    .output_freq             (output_freq),
    .search_current          (search_current),
    .fault_ack               (fault_ack),
    .restart_failed          (restart_failed),
    .start_success           (start_success)
  );
  mrs_motor_model u_motor (
    .pclk                  (pclk),
    .presetn               (presetn),
    .stage_on              (stage_on),
    .search_active         (search_active),
    .search_neg            (search_neg),
    .output_freq           (output_freq),
    .motor_speed           (motor_speed),
    .motor_neg             (motor_neg),
    .spinning              (spinning),
    .speed_found           (speed_found),
    .magnetizing_done_flag (magnetizing_done_flag),
    .fault_other           (fault_other)
  );

  always #25 pclk = ~pclk;

  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction

  function [31:0] rst_val(input integer i);
    case (i)
      1: rst_val = 32'h00006464;
      2: rst_val = 32'h00000300;
      3: rst_val = 32'h000003e8;
      default: rst_val = 32'h00000000;
    endcase
  endfunction

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 50) begin
        k = k + 1;
        @(posedge pclk);
      end
      if (pready !== 1'b1)
        mismatches = mismatches + 1;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task wait_bit(input integer b, input v, input integer lim);
    begin
      wt = 0;
      while (mon[b] !== v && wt < lim) begin
        wt = wt + 1;
        @(posedge pclk);
      end
    end
  endtask

  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  initial begin
    #3000000;
    mismatches = mismatches + 1;
    wrap_up;
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (m = 0; m < 5; m = m + 1) begin
      apb(0, (m == 4) ? 12'h01c : m * 4, 32'h00000000);
      chk(rd, rst_val(m));
      chk(err, m == 4);
    end
    // cold start of a spinning shaft must trip
    spinning <= 1'b1;
    run_command <= 1'b1;
    wait_bit(2, 1, 20);
    wait_bit(0, 1, 20);
    wait_bit(2, 0, 20);
    chk(stage_on, 0);
    run_command <= 1'b0;
    apb(1, 12'h010, 32'h00000001);
    // enable pin held low: the reset select keeps flying restart on
    for (m = 0; m < 3; m = m + 1) begin
      seed = xs(seed);
      magnetizing_current_ref <= seed[15:0];
      // first pass: shaft turns against the setpoint, only the reverse sweep finds it
      motor_neg <= (m != 1);
      setpoint_neg <= (m == 2);
      apb(1, 12'h004, (m == 2) ? 32'h0000c832 : 32'h00006432);
      apb(1, 12'h000, (m == 0) ? 32'h00000001 : 32'h00000004);
      run_command <= 1'b1;
      wait_bit(3, 1, 10);
      @(posedge pclk);
      chk(search_current, magnetizing_current_ref * 50 / 100);
      wait_bit(3, 0, 5000);
      chk(wt < 5000, 1);
      if (m == 1) t1 = wt;
      if (m == 2) t2 = wt;
      chk(output_freq, motor_speed);
      wait_bit(4, 1, 100);
      if (m == 0) begin
        wait_bit(7, 1, 25000);
        chk(wt > 1000 * MS && wt <= 1001 * MS, 1);
      end
      run_command <= 1'b0;
      wait_bit(2, 0, 2000);
    end
    chk(t2 > t1, 1);
    spinning <= 1'b0;
    apb(1, 12'h000, 32'h00000000);
    apb(1, 12'h00c, 32'h00000002);
    for (m = 0; m < 6; m = m + 1) begin
      apb(1, 12'h008, 32'h00000300 | modes[m]);
      run_command <= 1'b1;
      wait_bit(2, 1, 20);
      if (m % 2) fault_supply_loss <= 1'b1;
      else fault_undervolt <= 1'b1;
      run_command <= (modes[m] != 1);
      wait_bit(2, 0, 20);
      fault_supply_loss <= 1'b0;
      fault_undervolt <= 1'b0;
      wait_bit(6, 1, 100);
      t1 = wt;
      chk(wt < 100, modes[m] < 14 || modes[m] == 26);
      wait_bit(2, 1, 200);
      chk(wt < 200, modes[m] == 4 || modes[m] == 6 || modes[m] == 26);
      if (wt < 200) chk(wt > 2 * MS && wt <= 3 * MS + 2, 1);
      if (modes[m] >= 14 && modes[m] <= 16) begin
        apb(1, 12'h010, 32'h00000001);
        wait_bit(2, 1, 200);
        chk(wt < 200, 1);
      end
      run_command <= 1'b0;
      wait_bit(2, 0, 2000);
      apb(1, 12'h010, 32'h00000001);
    end
    // limit one: the second failed attempt gives up
    apb(1, 12'h008, 32'h00000106);
    run_command <= 1'b1;
    for (m = 0; m < 2; m = m + 1) begin
      wait_bit(2, 1, 200);
      fault_undervolt <= 1'b1;
      wait_bit(2, 0, 20);
      fault_undervolt <= 1'b0;
      wait_bit(5, 1, 100);
      chk(restart_failed, m);
    end
    wrap_up;
  end
endmodule
